// ==== core/psa_pkg.sv ====
`default_nettype none
package psa_pkg;

    // datapath geometry
    localparam int PSA_DATA_W = 128;
    localparam int PSA_CHUNK_W = 64;
    localparam int PSA_WORD_W = 16;
    localparam int PSA_BYTE_W = 8;
    localparam int PSA_DWORD_W = 32;
    localparam int PSA_WORDS_PER_CHUNK = 4;
    localparam int PSA_BYTES_PER_CHUNK = 8;
    localparam int PSA_DWORDS_PER_CHUNK = 2;
    localparam int PSA_IMM_W = 8;

    // largest byte-shift count that still keeps data
    localparam logic [7:0] PSA_SHIFT_MAX_BYTES = 8'h0f;

    // cycles from an accepted request to its result
    localparam int PSA_LATENCY_CYC = 1;

    // operation select
    typedef enum logic [4:0] {
        PSA_OP_SMAX_W,
        PSA_OP_SMIN_W,
        PSA_OP_UMAX_B,
        PSA_OP_UMIN_B,
        PSA_OP_MULHI_U_W,
        PSA_OP_MULHI_S_W,
        PSA_OP_SAD_B,
        PSA_OP_AVG_B,
        PSA_OP_AVG_W,
        PSA_OP_MADD_W,
        PSA_OP_UNSIGNED_DWORD_WIDENING_MUL,
        PSA_OP_QUADWORD_ADD,
        PSA_OP_QUADWORD_SUBTRACT,
        PSA_OP_BYTE_SHL,
        PSA_OP_BYTE_SHR,
        PSA_OP_ADD_W,
        PSA_OP_SUB_W,
        PSA_OP_ADDUS_B,
        PSA_OP_ADDUS_W,
        PSA_OP_SUBUS_B,
        PSA_OP_SUBUS_W
    } psa_op_t;

    // request from the issue logic
    typedef struct packed {
        logic valid;
        psa_op_t op;
        logic wide;
        logic use_mem;
        logic [PSA_IMM_W-1:0] imm;
        logic [PSA_DATA_W-1:0] src_a;
        logic [PSA_DATA_W-1:0] src_b_reg;
        logic [PSA_DATA_W-1:0] src_b_mem;
    } psa_req_t;

    // registered result
    typedef struct packed {
        logic valid;
        logic [PSA_DATA_W-1:0] data;
    } psa_res_t;

    // whole module state
    typedef struct packed {
        psa_res_t res;
    } psa_state_t;

    localparam psa_state_t PSA_STATE_RST = '0;

endpackage : psa_pkg
`default_nettype wire

// ==== core/psa_alu.sv ====
// Summary of operation
// - signed word max/min over four lanes
// - unsigned byte max/min over eight lanes
// - multiply-high keeps upper 16 product bits
// - byte abs-diff sum in low word
// - average adds one, shifts, keeps carry
// - average in byte and word variants
// - second source from register or memory
// - signed word multiply, pairwise add dwords
// - low dword unsigned multiply, full product
// - 64 or 128 bit width forms
// - quadword add/subtract wraps modulo 2^64
// - whole-register byte shift, zero fill
// - shift count above 15 clears result
// - unsigned saturating add/sub for bytes, words
// - plain word add discards lane carry
// - no doubleword unsigned saturating subtract
`timescale 1ns/100ps
`default_nettype none
module psa_alu
    import psa_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire psa_req_t req,
    output var psa_res_t res
);

    psa_state_t st_reg;
    psa_state_t st_next;

    // one 64-bit chunk of any lane-wise operation; nothing crosses a chunk edge
    function automatic logic [PSA_CHUNK_W-1:0] psa_chunk(
        input psa_op_t op,
        input logic [PSA_CHUNK_W-1:0] a,
        input logic [PSA_CHUNK_W-1:0] b
    );
        logic [PSA_CHUNK_W-1:0] r;
        logic [PSA_DWORD_W-1:0] p;
        logic [PSA_DWORD_W-1:0] p1;
        logic [PSA_WORD_W:0] s17;
        logic [PSA_BYTE_W:0] s9;
        logic [PSA_BYTE_W-1:0] d8;
        logic [PSA_WORD_W-1:0] sad;
        logic [PSA_WORD_W-1:0] aw;
        logic [PSA_WORD_W-1:0] bw;
        logic [PSA_BYTE_W-1:0] ab;
        logic [PSA_BYTE_W-1:0] bb;
        int i;
        r = '0;
        p = '0;
        p1 = '0;
        s17 = '0;
        s9 = '0;
        d8 = '0;
        sad = '0;
        unique case (op)
            PSA_OP_SMAX_W, PSA_OP_SMIN_W: begin
                for (i = 0; i < PSA_WORDS_PER_CHUNK; i++) begin
                    aw = a[i*PSA_WORD_W +: PSA_WORD_W];
                    bw = b[i*PSA_WORD_W +: PSA_WORD_W];
                    if (($signed(aw) > $signed(bw)) == (op == PSA_OP_SMAX_W)) begin
                        r[i*PSA_WORD_W +: PSA_WORD_W] = aw;
                    end else begin
                        r[i*PSA_WORD_W +: PSA_WORD_W] = bw;
                    end
                end
            end
            PSA_OP_UMAX_B, PSA_OP_UMIN_B: begin
                for (i = 0; i < PSA_BYTES_PER_CHUNK; i++) begin
                    ab = a[i*PSA_BYTE_W +: PSA_BYTE_W];
                    bb = b[i*PSA_BYTE_W +: PSA_BYTE_W];
                    if ((ab > bb) == (op == PSA_OP_UMAX_B)) begin
                        r[i*PSA_BYTE_W +: PSA_BYTE_W] = ab;
                    end else begin
                        r[i*PSA_BYTE_W +: PSA_BYTE_W] = bb;
                    end
                end
            end
            PSA_OP_MULHI_U_W, PSA_OP_MULHI_S_W: begin
                for (i = 0; i < PSA_WORDS_PER_CHUNK; i++) begin
                    aw = a[i*PSA_WORD_W +: PSA_WORD_W];
                    bw = b[i*PSA_WORD_W +: PSA_WORD_W];
                    if (op == PSA_OP_MULHI_S_W) begin
                        p = 32'($signed(aw) * $signed(bw));
                    end else begin
                        p = 32'(aw) * 32'(bw);
                    end
                    r[i*PSA_WORD_W +: PSA_WORD_W] = p[PSA_DWORD_W-1:PSA_WORD_W];
                end
            end
            PSA_OP_SAD_B: begin
                for (i = 0; i < PSA_BYTES_PER_CHUNK; i++) begin
                    ab = a[i*PSA_BYTE_W +: PSA_BYTE_W];
                    bb = b[i*PSA_BYTE_W +: PSA_BYTE_W];
                    d8 = (ab > bb) ? ab - bb : bb - ab;
                    sad = sad + 16'(d8);
                end
                r[PSA_WORD_W-1:0] = sad; // upper three words stay zero
            end
            PSA_OP_AVG_B: begin
                for (i = 0; i < PSA_BYTES_PER_CHUNK; i++) begin
                    s9 = {1'b0, a[i*PSA_BYTE_W +: PSA_BYTE_W]}
                        + {1'b0, b[i*PSA_BYTE_W +: PSA_BYTE_W]} + 9'h001;
                    r[i*PSA_BYTE_W +: PSA_BYTE_W] = s9[PSA_BYTE_W:1];
                end
            end
            PSA_OP_AVG_W: begin
                for (i = 0; i < PSA_WORDS_PER_CHUNK; i++) begin
                    s17 = {1'b0, a[i*PSA_WORD_W +: PSA_WORD_W]}
                        + {1'b0, b[i*PSA_WORD_W +: PSA_WORD_W]} + 17'h00001;
                    r[i*PSA_WORD_W +: PSA_WORD_W] = s17[PSA_WORD_W:1];
                end
            end
            PSA_OP_MADD_W: begin
                for (i = 0; i < PSA_DWORDS_PER_CHUNK; i++) begin
                    p = 32'($signed(a[i*32 +: 16]) * $signed(b[i*32 +: 16]));
                    p1 = 32'($signed(a[i*32+16 +: 16]) * $signed(b[i*32+16 +: 16]));
                    r[i*PSA_DWORD_W +: PSA_DWORD_W] = p + p1;
                end
            end
            PSA_OP_UNSIGNED_DWORD_WIDENING_MUL: begin
                r = 64'(a[PSA_DWORD_W-1:0]) * 64'(b[PSA_DWORD_W-1:0]);
            end
            PSA_OP_QUADWORD_ADD: begin
                r = a + b;
            end
            PSA_OP_QUADWORD_SUBTRACT: begin
                r = a - b;
            end
            PSA_OP_ADD_W, PSA_OP_SUB_W: begin
                for (i = 0; i < PSA_WORDS_PER_CHUNK; i++) begin
                    aw = a[i*PSA_WORD_W +: PSA_WORD_W];
                    bw = b[i*PSA_WORD_W +: PSA_WORD_W];
                    // carry or borrow out of the lane is dropped
                    r[i*PSA_WORD_W +: PSA_WORD_W] = (op == PSA_OP_ADD_W) ?
                        aw + bw : aw - bw;
                end
            end
            PSA_OP_ADDUS_B, PSA_OP_SUBUS_B: begin
                for (i = 0; i < PSA_BYTES_PER_CHUNK; i++) begin
                    ab = a[i*PSA_BYTE_W +: PSA_BYTE_W];
                    bb = b[i*PSA_BYTE_W +: PSA_BYTE_W];
                    s9 = {1'b0, ab} + {1'b0, bb};
                    if (op == PSA_OP_ADDUS_B) begin
                        r[i*PSA_BYTE_W +: PSA_BYTE_W] = s9[PSA_BYTE_W] ?
                            8'hff : s9[7:0];
                    end else begin
                        // byte and word are the only saturating subtract widths
                        r[i*PSA_BYTE_W +: PSA_BYTE_W] = (ab > bb) ?
                            ab - bb : 8'h00;
                    end
                end
            end
            PSA_OP_ADDUS_W, PSA_OP_SUBUS_W: begin
                for (i = 0; i < PSA_WORDS_PER_CHUNK; i++) begin
                    aw = a[i*PSA_WORD_W +: PSA_WORD_W];
                    bw = b[i*PSA_WORD_W +: PSA_WORD_W];
                    s17 = {1'b0, aw} + {1'b0, bw};
                    if (op == PSA_OP_ADDUS_W) begin
                        r[i*PSA_WORD_W +: PSA_WORD_W] = s17[PSA_WORD_W] ?
                            16'hffff : s17[15:0];
                    end else begin
                        r[i*PSA_WORD_W +: PSA_WORD_W] = (aw > bw) ?
                            aw - bw : 16'h0000;
                    end
                end
            end
            default: begin
                // byte shifts are whole-register and handled outside; illegal codes give zero
                r = '0;
            end
        endcase
        return r;
    endfunction : psa_chunk

    // operand select, per-chunk compute, byte shifts and result capture
    always_comb begin
        logic [PSA_DATA_W-1:0] src_b;
        logic [PSA_DATA_W-1:0] calc;
        logic [6:0] shamt;
        src_b = '0;
        calc = '0;
        shamt = '0;
        st_next = st_reg;
        src_b = req.use_mem ? req.src_b_mem : req.src_b_reg;
        shamt = {req.imm[3:0], 3'b000};
        calc[PSA_CHUNK_W-1:0] = psa_chunk(req.op, req.src_a[PSA_CHUNK_W-1:0],
            src_b[PSA_CHUNK_W-1:0]);
        if (req.wide) begin
            // high half is a second independent operation
            calc[PSA_DATA_W-1:PSA_CHUNK_W] = psa_chunk(req.op,
                req.src_a[PSA_DATA_W-1:PSA_CHUNK_W],
                src_b[PSA_DATA_W-1:PSA_CHUNK_W]);
        end
        if (req.op == PSA_OP_BYTE_SHL || req.op == PSA_OP_BYTE_SHR) begin
            if (req.imm > PSA_SHIFT_MAX_BYTES) begin
                calc = '0;
            end else if (req.op == PSA_OP_BYTE_SHL) begin
                calc = req.src_a << shamt;
            end else begin
                calc = req.src_a >> shamt;
            end
        end
        st_next.res.valid = req.valid;
        if (req.valid) begin
            st_next.res.data = calc;
        end
    end

    // state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= PSA_STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign res = st_reg.res;

endmodule : psa_alu
`default_nettype wire

// ==== dv/psa_alu_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module psa_alu_sva
    import psa_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire psa_req_t req,
    input wire psa_res_t res
);
    // second source as the datapath should pick it
    logic [PSA_DATA_W-1:0] b_sel;
    assign b_sel = req.use_mem ? req.src_b_mem : req.src_b_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_take(psa_op_t o);
        req.valid && req.op == o;
    endsequence
    property p_res_one_later;
        req.valid |=> res.valid;
    endproperty
    a_res_one_later: assert property (p_res_one_later)
        else $error("result strobe missing");
    property p_no_spurious;
        !req.valid |=> !res.valid;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("result strobe unasked");
    property p_data_holds;
        !req.valid |=> $stable(res.data);
    endproperty
    a_data_holds: assert property (p_data_holds)
        else $error("result changed while idle");
    property p_word_add;
        s_take(PSA_OP_ADD_W) |=> res.data[15:0] == $past(16'(req.src_a[15:0] + b_sel[15:0]));
    endproperty
    a_word_add: assert property (p_word_add) else $error("word add lane wrong");
    property p_quad_sub;
        s_take(PSA_OP_QUADWORD_SUBTRACT) |=>
            res.data[63:0] == $past(64'(req.src_a[63:0] - b_sel[63:0]));
    endproperty
    a_quad_sub: assert property (p_quad_sub) else $error("quadword subtract wrong");
    property p_shift_clear;
        req.valid && (req.op == PSA_OP_BYTE_SHL || req.op == PSA_OP_BYTE_SHR)
            && req.imm > PSA_SHIFT_MAX_BYTES |=> res.data == '0;
    endproperty
    a_shift_clear: assert property (p_shift_clear)
        else $error("long shift not zero");
    property p_narrow_high;
        req.valid && !req.wide && req.op != PSA_OP_BYTE_SHL && req.op != PSA_OP_BYTE_SHR
            |=> res.data[127:64] == '0;
    endproperty
    a_narrow_high: assert property (p_narrow_high)
        else $error("narrow form high half set");
    property p_sad_upper;
        s_take(PSA_OP_SAD_B) |=> res.data[63:16] == '0;
    endproperty
    a_sad_upper: assert property (p_sad_upper) else $error("sad upper words set");
endmodule : psa_alu_sva
bind psa_alu psa_alu_sva i_sva (.core_clk(core_clk), .rst(rst), .req(req), .res(res));
`default_nettype wire

// ==== dv/psa_issue_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module psa_issue_model
    import psa_pkg::*;
(
    input wire logic core_clk,
    output var psa_req_t req
);
    initial req = '0;
    // one request after an edge, left up so requests run back to back
    task automatic send(input psa_op_t op, input logic [7:0] imm, input logic wide,
        input logic mem, input logic [127:0] a, input logic [127:0] b);
        @(posedge core_clk);
        #1;
        req = '{1'b1, op, wide, mem, imm, a, mem ? ~b : b, mem ? b : ~b};
    endtask : send
    // drop the strobe
    task automatic idle();
        @(posedge core_clk);
        #1;
        req.valid = 1'b0;
    endtask : idle
endmodule : psa_issue_model
`default_nettype wire

// ==== dv/tb_packed_simd_integer_alu.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_packed_simd_integer_alu;
    import psa_pkg::*;
    logic core_clk;
    logic rst;
    psa_req_t req;
    psa_res_t res;
    int errors;
    int n_tests;
    logic [PSA_DATA_W:0] exp_q[$];
    logic [PSA_DATA_W-1:0] last;
    logic [PSA_DATA_W-1:0] pat[4];
    psa_alu i_dut (.core_clk(core_clk), .rst(rst), .req(req), .res(res));
    psa_issue_model i_iss (.core_clk(core_clk), .req(req));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // one 64-bit chunk, lane by lane
    function automatic logic [63:0] ref64(psa_op_t op, logic [63:0] a, logic [63:0] b);
        logic [63:0] r;
        logic [15:0] u, v;
        logic [16:0] t;
        logic [31:0] p, q;
        int s;
        r = '0;
        s = 0;
        for (int i = 0; i < 8; i++) begin
            u = 16'(a[i*8+:8]);
            v = 16'(b[i*8+:8]);
            t = u + v;
            case (op)
                PSA_OP_UMAX_B: r[i*8+:8] = 8'((u > v) ? u : v);
                PSA_OP_UMIN_B: r[i*8+:8] = 8'((u < v) ? u : v);
                PSA_OP_SAD_B: s += (u > v) ? u - v : v - u;
                PSA_OP_AVG_B: r[i*8+:8] = 8'((t + 1) >> 1);
                PSA_OP_ADDUS_B: r[i*8+:8] = t[8] ? 8'hff : t[7:0];
                PSA_OP_SUBUS_B: r[i*8+:8] = 8'((u > v) ? u - v : 16'h0);
                default: ;
            endcase
        end
        for (int i = 0; i < 4; i++) begin
            u = a[i*16+:16];
            v = b[i*16+:16];
            t = u + v;
            p = $signed(u) * $signed(v);
            q = u * v;
            case (op)
                PSA_OP_SMAX_W: r[i*16+:16] = ($signed(u) > $signed(v)) ? u : v;
                PSA_OP_SMIN_W: r[i*16+:16] = ($signed(u) < $signed(v)) ? u : v;
                PSA_OP_MULHI_U_W: r[i*16+:16] = q[31:16];
                PSA_OP_MULHI_S_W: r[i*16+:16] = p[31:16];
                PSA_OP_AVG_W: r[i*16+:16] = 16'((t + 1) >> 1);
                PSA_OP_MADD_W: r[i/2*32+:32] += p;
                PSA_OP_ADD_W: r[i*16+:16] = t[15:0];
                PSA_OP_SUB_W: r[i*16+:16] = u - v;
                PSA_OP_ADDUS_W: r[i*16+:16] = t[16] ? 16'hffff : t[15:0];
                PSA_OP_SUBUS_W: r[i*16+:16] = (u > v) ? u - v : 16'h0;
                default: ;
            endcase
        end
        case (op)
            PSA_OP_SAD_B: r = 64'(s);
            PSA_OP_UNSIGNED_DWORD_WIDENING_MUL: r = a[31:0] * b[31:0];
            PSA_OP_QUADWORD_ADD: r = a + b;
            PSA_OP_QUADWORD_SUBTRACT: r = a - b;
            default: ;
        endcase
        return r;
    endfunction : ref64
    // whole result for a request
    function automatic logic [PSA_DATA_W-1:0] exp128(psa_req_t r);
        logic [PSA_DATA_W-1:0] b;
        b = r.use_mem ? r.src_b_mem : r.src_b_reg;
        case (r.op)
            PSA_OP_BYTE_SHL: return (r.imm > 8'h0f) ? '0 : r.src_a << (8 * r.imm);
            PSA_OP_BYTE_SHR: return (r.imm > 8'h0f) ? '0 : r.src_a >> (8 * r.imm);
            default: return {r.wide ? ref64(r.op, r.src_a[127:64], b[127:64]) : 64'h0,
                ref64(r.op, r.src_a[63:0], b[63:0])};
        endcase
    endfunction : exp128
    function automatic logic [PSA_DATA_W-1:0] rnd();
        return {$urandom, $urandom, $urandom, $urandom};
    endfunction : rnd
    task automatic check(input logic [PSA_DATA_W:0] seen, input logic [PSA_DATA_W:0] want);
        n_tests++;
        if (seen !== want) begin
            errors++;
            $display("FAIL %0t result %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    // record what each accepted request should give
    always @(posedge core_clk) begin
        if (!rst && req.valid) begin
            exp_q.push_back({1'b1, exp128(req)});
        end
    end
    // compare the registered result mid cycle
    always @(negedge core_clk) begin
        if (!rst && exp_q.size() > 0) begin
            last = exp_q[0][PSA_DATA_W-1:0];
            check({res.valid, res.data}, exp_q.pop_front());
        end else if (!rst) begin
            check({res.valid, res.data}, {1'b0, last});
        end
    end
    initial begin
        errors = 0;
        n_tests = 0;
        last = '0;
        rst = 1'b1;
        pat = '{'0, '1, {8{16'h8000}}, {16{8'h7f}}};
        void'($urandom(86656));
        repeat (3) @(posedge core_clk);
        #1;
        check({res.valid, res.data}, '0);
        rst = 1'b0;
        // random operands on every operation, back to back
        repeat (20) begin
            for (int k = 0; k < 21; k++) begin
                i_iss.send(psa_op_t'(k), 8'($urandom_range(20)), 1'($urandom),
                    1'($urandom), rnd(), rnd());
            end
        end
        i_iss.idle();
        $display("random test done");
        // reset in mid run must clear a standing result
        repeat (2) @(posedge core_clk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        check({res.valid, res.data}, '0);
        last = '0;
        rst = 1'b0;
        $display("reset test done");
        // carry, sign and saturation corners
        for (int k = 0; k < 21; k++) begin
            for (int m = 0; m < 16; m++) begin
                i_iss.send(psa_op_t'(k), 8'hff, 1'b1, m[0], pat[m%4], pat[m/4]);
            end
        end
        $display("corner test done");
        // byte shift counts around the limit
        for (int n = 0; n < 20; n++) begin
            i_iss.send(PSA_OP_BYTE_SHL, 8'(n), 1'b0, 1'b0, rnd(), rnd());
            i_iss.send(PSA_OP_BYTE_SHR, 8'(n), 1'b1, 1'b1, rnd(), rnd());
        end
        i_iss.idle();
        repeat (3) @(posedge core_clk);
        $display("shift test done");
        print_verdict();
    end
    // cut a hang short
    initial begin
        #20000;
        errors++;
        print_verdict();
    end
endmodule : tb_packed_simd_integer_alu
`default_nettype wire
